/* File: core/chan_decode_pkg.sv */
package chan_decode_pkg;

  // ******************************************************
  // register map (byte addresses)
  // ******************************************************
  localparam logic [7:0] CMD_OFS        = 8'h00;
  localparam logic [7:0] PRESET_OFS     = 8'h04;
  localparam logic [7:0] RESULT_OFS     = 8'h08;
  localparam logic [7:0] STATUS_OFS     = 8'h0c;
  localparam logic [7:0] INT_STATUS_OFS = 8'h10;
  localparam logic [7:0] INT_CLEAR_OFS  = 8'h14;
  localparam logic [7:0] INT_ENABLE_OFS = 8'h18;
  localparam logic [7:0] CONFIG_OFS     = 8'h1c;
  localparam logic [7:0] MASK_OFS       = 8'h20;
  localparam logic [1:0] SNAP_BASE      = 2'h1;

  // ******************************************************
  // fields and constants
  // ******************************************************
  localparam int         NCH         = 16;
  localparam int         LOG_MSB     = 6;
  localparam int         OP_LSB      = 8;
  localparam int         OP_MSB      = 11;
  localparam int         EDGE_LSB    = 12;
  localparam int         EDGE_MSB    = 13;
  localparam logic [6:0] NCH_WIDE    = 7'h10;
  localparam logic [6:0] NCH_NARROW  = 7'h08;
  localparam logic [6:0] GROUP_CNT   = 7'h5a;
  localparam logic [6:0] GROUP_LVL   = 7'h5b;
  localparam logic [15:0] MASK_WIDE   = 16'hffff;
  localparam logic [15:0] MASK_NARROW = 16'h00ff;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_NONE   = 2'h0;
  localparam logic       WIDE_RESET  = 1'b1;
  localparam logic [15:0][1:0] EDGE_RESET = {16{2'h1}};
  localparam logic [31:0] COUNT_MAX  = 32'hffffffff;

  // ******************************************************
  // types
  // ******************************************************
  typedef enum logic [3:0] {
    OP_VALUE_READ  = 4'h0,
    OP_MULTI_READ  = 4'h1,
    OP_READ_CLEAR  = 4'h2,
    OP_PRESET      = 4'h3,
    OP_ARM         = 4'h4,
    OP_DISARM      = 4'h5,
    OP_EDGE        = 4'h6,
    OP_SLOT_READ   = 4'h7,
    OP_MULTI_SLOT  = 4'h8,
    OP_CONFIGURE   = 4'h9
  } op_type;

  typedef enum logic [2:0] {
    TARGET_NONE    = 3'h0,
    TARGET_COUNTER = 3'h1,
    TARGET_LEVEL   = 3'h2,
    GROUP_COUNTERS = 3'h3,
    GROUP_LEVELS   = 3'h4
  } target_type;

  typedef struct packed {
    target_type target;
    logic [3:0] phys;
  } decode_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_type;

  typedef struct packed {
    logic [15:0] meta;
    logic [15:0] sync;
    logic [15:0] prev;
  } sync_state_type;

endpackage : chan_decode_pkg

/* File: core/channel_command_core.sv */
// Operation
// - wide variant has channels 0 to 15, narrow variant 0 to 7.
// - each channel has two logical numbers selecting channel and function.
// - wide: 0-15 counters, 16-31 levels of same channels.
// - narrow: 0-7 counters, 8-15 levels of same channels.
// - value reads on counter numbers return edge counts.
// - value reads on level numbers return the input level bit.
// - counter preset accepted only on counter numbers, loads preset value.
// - disarm on counter number stops counter-overflow interrupts.
// - disarm on level number stops edge-event interrupts.
// - arm on counter number enables overflow interrupt.
// - arm on level number enables event interrupt on selected edge.
// - narrow: number 0 arms counter, number 8 arms event, channel 0.
// - number 90 groups all counters; disarm clears all overflow arming.
// - number 91 groups all levels; disarm or arm every event.
// - one edge select drives both counting and event interrupts.
// - slot read on level numbers returns all levels; multi form repeats.
// - slot result has channel 0 in LSB, one meaning high.
// - configure resets rising edge, zero count, interrupts cleared, disarmed.
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module channel_command_core (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic [7:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  input  wire logic [15:0] DIN,
  output logic             IRQ
);

  // ******************************************************
  // state
  // ******************************************************
  typedef struct packed {
    chan_decode_pkg::bus_state_type bus;
    logic [31:0]       rdata;
    logic [15:0][31:0] count;
    logic [15:0][31:0] snap;
    logic [15:0][1:0]  edge_sel;
    logic [15:0]       cnt_stat;
    logic [15:0]       evt_stat;
    logic [15:0]       cnt_en;
    logic [15:0]       evt_en;
    logic [15:0]       mask;
    logic [31:0]       preset;
    logic [31:0]       result;
    logic              wide;
    logic              reject;
  } core_state_type;

  core_state_type              st_reg;
  core_state_type              st_next;
  chan_decode_pkg::decode_type dec;
  chan_decode_pkg::op_type     op;
  logic [15:0]                 level;
  logic [15:0]                 hit;
  logic [15:0]                 ovf;
  logic [15:0]                 chmask;
  logic [31:0]                 rd_word;
  logic [31:0]                 sel_count;
  logic [1:0]                  edge_code;
  logic                        req;
  logic                        in_ack;
  logic                        wr_cmd;
  logic                        is_cnt;
  logic                        is_lvl;

  // ******************************************************
  // submodules
  // ******************************************************
  input_edge_sync u_sync (
    .clock    (CLOCK),
    .reset    (RESET),
    .pin      (DIN),
    .edge_sel (st_reg.edge_sel),
    .level    (level),
    .hit      (hit)
  );

  logical_decoder u_dec (
    .logical (WRITEDATA[chan_decode_pkg::LOG_MSB:0]),
    .wide    (st_reg.wide),
    .dec     (dec)
  );

  // ******************************************************
  // bus handshake and decode helpers
  // ******************************************************
  assign req         = READ || WRITE;
  assign in_ack      = (st_reg.bus == chan_decode_pkg::BUS_ACK);
  assign WAITREQUEST = req && !in_ack;
  assign READDATA    = st_reg.rdata;
  assign IRQ         = |({st_reg.evt_stat, st_reg.cnt_stat}
                       & {st_reg.evt_en, st_reg.cnt_en});
  // narrow variant ignores the upper eight inputs
  assign chmask      = st_reg.wide ? chan_decode_pkg::MASK_WIDE
                                   : chan_decode_pkg::MASK_NARROW;
  assign wr_cmd      = WRITE && in_ack
                       && (ADDRESS == chan_decode_pkg::CMD_OFS);
  assign op          = chan_decode_pkg::op_type'(
                       WRITEDATA[chan_decode_pkg::OP_MSB:
                                 chan_decode_pkg::OP_LSB]);
  assign edge_code   = WRITEDATA[chan_decode_pkg::EDGE_MSB:
                                 chan_decode_pkg::EDGE_LSB];
  assign is_cnt      = (dec.target == chan_decode_pkg::TARGET_COUNTER);
  assign is_lvl      = (dec.target == chan_decode_pkg::TARGET_LEVEL);
  assign sel_count   = st_reg.count[dec.phys];

  for (genvar i = 0; i < chan_decode_pkg::NCH; i++)
  begin : g_ovf
    assign ovf[i] = hit[i] && chmask[i]
                    && (st_reg.count[i] == chan_decode_pkg::COUNT_MAX);
  end

  // read word is latched one cycle before the answer
  always_comb
  begin
    rd_word = 32'h0;
    if (ADDRESS == chan_decode_pkg::RESULT_OFS)
      rd_word = st_reg.result;
    else if (ADDRESS == chan_decode_pkg::STATUS_OFS)
      rd_word = {30'h0, st_reg.wide, st_reg.reject};
    else if (ADDRESS == chan_decode_pkg::INT_STATUS_OFS)
      rd_word = {st_reg.evt_stat, st_reg.cnt_stat};
    else if (ADDRESS == chan_decode_pkg::INT_ENABLE_OFS)
      rd_word = {st_reg.evt_en, st_reg.cnt_en};
    else if (ADDRESS == chan_decode_pkg::PRESET_OFS)
      rd_word = st_reg.preset;
    else if (ADDRESS == chan_decode_pkg::CONFIG_OFS)
      rd_word = {31'h0, st_reg.wide};
    else if (ADDRESS == chan_decode_pkg::MASK_OFS)
      rd_word = {16'h0, st_reg.mask};
    else if (ADDRESS[7:6] == chan_decode_pkg::SNAP_BASE)
      rd_word = st_reg.snap[ADDRESS[5:2]];
  end

  // ******************************************************
  // next state
  // ******************************************************
  always_comb
  begin
    st_next = st_reg;
    for (int i = 0; i < chan_decode_pkg::NCH; i++)
    begin
      if (hit[i] && chmask[i])
        st_next.count[i] = st_reg.count[i] + 32'h1;
    end
    case (st_reg.bus)
      chan_decode_pkg::BUS_IDLE:
      begin
        if (req)
        begin
          st_next.bus   = chan_decode_pkg::BUS_ACK;
          // writes leave the last read word standing
          st_next.rdata = READ ? rd_word : st_reg.rdata;
        end
      end
      chan_decode_pkg::BUS_ACK:
      begin
        st_next.bus = chan_decode_pkg::BUS_IDLE;
        if (wr_cmd)
        begin
          st_next.reject = 1'b0;
          case (op)
            chan_decode_pkg::OP_VALUE_READ:
            begin
              if (is_cnt)
                st_next.result = sel_count;
              else if (is_lvl)
                st_next.result = {31'h0, level[dec.phys]};
              else
                st_next.reject = 1'b1;
            end
            chan_decode_pkg::OP_MULTI_READ:
            begin
              if (is_cnt || is_lvl)
              begin
                st_next.result = {16'h0, st_reg.mask & chmask};
                for (int i = 0; i < chan_decode_pkg::NCH; i++)
                begin
                  st_next.snap[i] = 32'h0;
                  if (st_reg.mask[i] && chmask[i])
                    st_next.snap[i] = is_cnt ? st_reg.count[i]
                                    : {31'h0, level[i]};
                end
              end
              else
                st_next.reject = 1'b1;
            end
            chan_decode_pkg::OP_READ_CLEAR:
            begin
              if (is_cnt)
              begin
                st_next.result = sel_count;
                st_next.count[dec.phys] = 32'h0;
              end
              else
                st_next.reject = 1'b1;
            end
            chan_decode_pkg::OP_PRESET:
            begin
              if (is_cnt)
                st_next.count[dec.phys] = st_reg.preset;
              else
                st_next.reject = 1'b1;
            end
            chan_decode_pkg::OP_ARM:
            begin
              if (is_cnt)
                st_next.cnt_en[dec.phys] = 1'b1;
              else if (is_lvl)
                st_next.evt_en[dec.phys] = 1'b1;
              else if (dec.target == chan_decode_pkg::GROUP_COUNTERS)
                st_next.cnt_en = st_reg.cnt_en | chmask;
              else if (dec.target == chan_decode_pkg::GROUP_LEVELS)
                st_next.evt_en = st_reg.evt_en | chmask;
              else
                st_next.reject = 1'b1;
            end
            chan_decode_pkg::OP_DISARM:
            begin
              if (is_cnt)
                st_next.cnt_en[dec.phys] = 1'b0;
              else if (is_lvl)
                st_next.evt_en[dec.phys] = 1'b0;
              else if (dec.target == chan_decode_pkg::GROUP_COUNTERS)
                st_next.cnt_en = st_reg.cnt_en & ~chmask;
              else if (dec.target == chan_decode_pkg::GROUP_LEVELS)
                st_next.evt_en = st_reg.evt_en & ~chmask;
              else
                st_next.reject = 1'b1;
            end
            chan_decode_pkg::OP_EDGE:
            begin
              if (edge_code == chan_decode_pkg::EDGE_NONE
                  || dec.target == chan_decode_pkg::TARGET_NONE)
                st_next.reject = 1'b1;
              else if (is_cnt || is_lvl)
                st_next.edge_sel[dec.phys] = edge_code;
              else
              begin
                for (int i = 0; i < chan_decode_pkg::NCH; i++)
                begin
                  if (chmask[i])
                    st_next.edge_sel[i] = edge_code;
                end
              end
            end
            chan_decode_pkg::OP_SLOT_READ:
            begin
              if (is_lvl)
                st_next.result = {16'h0, level & chmask};
              else
                st_next.reject = 1'b1;
            end
            chan_decode_pkg::OP_MULTI_SLOT:
            begin
              if (is_lvl)
              begin
                // one slot here: every requested entry holds its vector
                st_next.result = {16'h0, level & chmask};
                for (int i = 0; i < chan_decode_pkg::NCH; i++)
                begin
                  st_next.snap[i] = st_reg.mask[i]
                                  ? {16'h0, level & chmask}
                                  : 32'h0;
                end
              end
              else
                st_next.reject = 1'b1;
            end
            chan_decode_pkg::OP_CONFIGURE:
            begin
              if (is_cnt || is_lvl)
              begin
                st_next.edge_sel[dec.phys] =
                  chan_decode_pkg::EDGE_RISING;
                st_next.count[dec.phys]    = 32'h0;
                st_next.cnt_en[dec.phys]   = 1'b0;
                st_next.evt_en[dec.phys]   = 1'b0;
                st_next.cnt_stat[dec.phys] = 1'b0;
                st_next.evt_stat[dec.phys] = 1'b0;
              end
              else
                st_next.reject = 1'b1;
            end
            default:
              st_next.reject = 1'b1;
          endcase
        end
        else if (WRITE)
        begin
          if (ADDRESS == chan_decode_pkg::PRESET_OFS)
            st_next.preset = WRITEDATA;
          else if (ADDRESS == chan_decode_pkg::INT_CLEAR_OFS)
          begin
            st_next.cnt_stat = st_reg.cnt_stat & ~WRITEDATA[15:0];
            st_next.evt_stat = st_reg.evt_stat & ~WRITEDATA[31:16];
          end
          else if (ADDRESS == chan_decode_pkg::INT_ENABLE_OFS)
          begin
            st_next.cnt_en = WRITEDATA[15:0];
            st_next.evt_en = WRITEDATA[31:16];
          end
          else if (ADDRESS == chan_decode_pkg::CONFIG_OFS)
            st_next.wide = WRITEDATA[0];
          else if (ADDRESS == chan_decode_pkg::MASK_OFS)
            st_next.mask = WRITEDATA[15:0];
        end
      end
      default:
        st_next.bus = chan_decode_pkg::BUS_IDLE;
    endcase
    // sets come last so an event beats a clear in the same cycle
    st_next.cnt_stat = st_next.cnt_stat | (ovf & st_reg.cnt_en);
    st_next.evt_stat = st_next.evt_stat
                     | (hit & chmask & st_reg.evt_en);
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      st_reg          <= '0;
      st_reg.edge_sel <= chan_decode_pkg::EDGE_RESET;
      st_reg.wide     <= chan_decode_pkg::WIDE_RESET;
    end
    else
      st_reg <= st_next;
  end

  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);

  wide_map_a: assert property (
    st_reg.wide && wr_cmd && WRITEDATA[6:0] >= 7'h10
    && WRITEDATA[6:0] < 7'h20
    |-> is_lvl && dec.phys == WRITEDATA[3:0])
    else $error("wide level number decoded wrongly");

  narrow_map_a: assert property (
    !st_reg.wide && wr_cmd && WRITEDATA[6:0] >= 7'h08
    && WRITEDATA[6:0] < 7'h10
    |-> is_lvl && dec.phys == {1'b0, WRITEDATA[2:0]})
    else $error("narrow level number decoded wrongly");

  count_read_a: assert property (
    wr_cmd && op == chan_decode_pkg::OP_VALUE_READ && is_cnt
    |=> st_reg.result == $past(sel_count))
    else $error("count read returned wrong value");

  preset_load_a: assert property (
    wr_cmd && op == chan_decode_pkg::OP_PRESET && is_cnt
    |=> st_reg.count[$past(dec.phys)] == $past(st_reg.preset))
    else $error("preset not loaded");

  arm_event_a: assert property (
    wr_cmd && op == chan_decode_pkg::OP_ARM && is_lvl
    |=> st_reg.evt_en[$past(dec.phys)])
    else $error("event arm lost");

  group_disarm_a: assert property (
    wr_cmd && op == chan_decode_pkg::OP_DISARM
    && dec.target == chan_decode_pkg::GROUP_COUNTERS
    |=> (st_reg.cnt_en & chmask) == 16'h0)
    else $error("group disarm left counter armed");

  configure_a: assert property (
    wr_cmd && op == chan_decode_pkg::OP_CONFIGURE && is_cnt
    |=> st_reg.edge_sel[$past(dec.phys)] == chan_decode_pkg::EDGE_RISING
        && !st_reg.cnt_en[$past(dec.phys)]
        && !st_reg.evt_en[$past(dec.phys)])
    else $error("configure did not restore defaults");

  reject_keep_a: assert property (
    wr_cmd && dec.target == chan_decode_pkg::TARGET_NONE
    |=> st_reg.reject && $stable(st_reg.cnt_en)
        && $stable(st_reg.evt_en) && $stable(st_reg.edge_sel))
    else $error("rejected command changed state");

  bus_answer_a: assert property (
    req && WAITREQUEST |=> !WAITREQUEST || !req)
    else $error("bus answer later than one cycle");

endmodule : channel_command_core

/* File: core/input_edge_sync.sv */
`timescale 1ns/1ps
module input_edge_sync (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [15:0]      pin,
  input  wire logic [15:0][1:0] edge_sel,
  output logic      [15:0]      level,
  output logic      [15:0]      hit
);

  chan_decode_pkg::sync_state_type st_reg;
  chan_decode_pkg::sync_state_type st_next;

  // meta feeds sync only; prev lags sync for edge detect
  always_comb
  begin
    st_next      = st_reg;
    st_next.meta = pin;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign level = st_reg.sync;

  // one edge select serves counting and event alike
  for (genvar i = 0; i < chan_decode_pkg::NCH; i++)
  begin : g_hit
    assign hit[i] = (edge_sel[i][0] & st_reg.sync[i] & ~st_reg.prev[i])
                  | (edge_sel[i][1] & ~st_reg.sync[i] & st_reg.prev[i]);
  end

endmodule : input_edge_sync

/* File: core/logical_decoder.sv */
`timescale 1ns/1ps
module logical_decoder (
  input  wire logic [6:0]               logical,
  input  wire logic                     wide,
  output chan_decode_pkg::decode_type   dec
);

  logic [6:0] nch;
  logic [6:0] off;

  assign nch = wide ? chan_decode_pkg::NCH_WIDE
                    : chan_decode_pkg::NCH_NARROW;
  assign off = logical - nch;

  // low range counts, next range senses level
  always_comb
  begin
    dec.phys   = 4'h0;
    dec.target = chan_decode_pkg::TARGET_NONE;
    if (logical < nch)
    begin
      dec.target = chan_decode_pkg::TARGET_COUNTER;
      dec.phys   = logical[3:0];
    end
    else if (off < nch)
    begin
      dec.target = chan_decode_pkg::TARGET_LEVEL;
      dec.phys   = off[3:0];
    end
    else if (logical == chan_decode_pkg::GROUP_CNT)
      dec.target = chan_decode_pkg::GROUP_COUNTERS;
    else if (logical == chan_decode_pkg::GROUP_LVL)
      dec.target = chan_decode_pkg::GROUP_LEVELS;
  end

endmodule : logical_decoder

/* File: verification/controller_model.sv */
`timescale 1ns/1ps
module controller_model (
  input  wire logic        clock,
  input  wire logic        waitrequest,
  output logic      [7:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata
);
  // ****************************************
  // avalon master
  // ****************************************
  initial
  begin
    address   = 8'h00;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0;
  end

  task automatic access(input logic rd, input logic [7:0] a,
                        input logic [31:0] d);
    @(posedge clock);
    address   <= a;
    writedata <= d;
    read      <= rd;
    write     <= !rd;
    // only the bench watchdog ends a wait that never answers
    do
    begin
      @(posedge clock);
    end
    while (waitrequest !== 1'b0);
    read      <= 1'b0;
    write     <= 1'b0;
    // released lines must not keep the old value
    address   <= ~a;
    writedata <= ~d;
  endtask : access
endmodule : controller_model

/* File: verification/digital_input_channel_decode_test.sv */
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("unexpected %s expected %h seen %h", what, exp, got); \
    end \
  end
module digital_input_channel_decode_test;
  logic        CLOCK, RESET, READ, WRITE, WAITREQUEST, IRQ;
  logic [7:0]  ADDRESS;
  logic [31:0] WRITEDATA, READDATA, e;
  logic [15:0] DIN, r;
  logic [31:0] exp_q[$];
  int          n_errors, compares, n;

  channel_command_core DUT (.CLOCK(CLOCK), .RESET(RESET),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .DIN(DIN), .IRQ(IRQ));
  controller_model host (.clock(CLOCK), .waitrequest(WAITREQUEST),
    .address(ADDRESS), .read(READ), .write(WRITE), .writedata(WRITEDATA));

  initial
  begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  // ****************************************
  // result monitor
  // ****************************************
  always @(posedge CLOCK)
    if (READ && WAITREQUEST === 1'b0)
    begin
      e = exp_q.pop_front();
      `CHECK($sformatf("reg %h", ADDRESS), e, READDATA)
    end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.access(1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    host.access(1'b1, a, 32'h0);
  endtask : rd
  task automatic cmd(input logic [3:0] op, input logic [6:0] l,
                     input logic [1:0] ed = 2'h1);
    wr(chan_decode_pkg::CMD_OFS, {18'h0, ed, op, 1'b0, l});
  endtask : cmd
  // sync plus edge detect needs about 3 edges; 4 leaves margin
  task automatic pulse(input int ch, input int k);
    repeat (k)
    begin
      DIN[ch] <= 1'b1;
      repeat (4) @(posedge CLOCK);
      DIN[ch] <= 1'b0;
      repeat (4) @(posedge CLOCK);
    end
  endtask : pulse
  task automatic do_reset;
    RESET <= 1'b1;
    DIN   <= 16'h0;
    repeat (6) @(posedge CLOCK);
    RESET <= 1'b0;
  endtask : do_reset
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (20000) @(posedge CLOCK);
    n_errors++;
    wrap_up();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    RESET = 1'b1;
    DIN   = 16'h0;
    void'($urandom(51));
    do_reset();
    rd(chan_decode_pkg::STATUS_OFS, 32'h2);
    rd(8'h3c, 32'h0);
    n = $urandom_range(4, 1);
    pulse(3, n);
    cmd(chan_decode_pkg::OP_VALUE_READ, 7'd3);
    rd(chan_decode_pkg::RESULT_OFS, n);
    cmd(chan_decode_pkg::OP_EDGE, 7'd3, 2'h3);
    pulse(3, 1);
    DIN[3] <= 1'b1;
    repeat (4) @(posedge CLOCK);
    cmd(chan_decode_pkg::OP_VALUE_READ, 7'd19);
    rd(chan_decode_pkg::RESULT_OFS, 32'h1);
    cmd(chan_decode_pkg::OP_READ_CLEAR, 7'd3);
    rd(chan_decode_pkg::RESULT_OFS, n + 3);
    cmd(chan_decode_pkg::OP_VALUE_READ, 7'd3);
    rd(chan_decode_pkg::RESULT_OFS, 32'h0);
    // counter overflow on channel 5
    wr(chan_decode_pkg::PRESET_OFS, 32'hffffffff);
    cmd(chan_decode_pkg::OP_PRESET, 7'd5);
    cmd(chan_decode_pkg::OP_ARM, 7'd5);
    rd(chan_decode_pkg::INT_ENABLE_OFS, 32'h20);
    pulse(5, 1);
    rd(chan_decode_pkg::INT_STATUS_OFS, 32'h20);
    `CHECK("irq", 1'b1, IRQ)
    wr(chan_decode_pkg::INT_CLEAR_OFS, 32'h20);
    cmd(chan_decode_pkg::OP_DISARM, 7'd5);
    rd(chan_decode_pkg::INT_ENABLE_OFS, 32'h0);
    cmd(chan_decode_pkg::OP_PRESET, 7'd5);
    pulse(5, 1);
    rd(chan_decode_pkg::INT_STATUS_OFS, 32'h0);
    // edge event on channel 2
    cmd(chan_decode_pkg::OP_ARM, 7'd18);
    pulse(2, 1);
    rd(chan_decode_pkg::INT_STATUS_OFS, 32'h40000);
    cmd(chan_decode_pkg::OP_DISARM, 7'd18);
    wr(chan_decode_pkg::INT_CLEAR_OFS, 32'h40000);
    pulse(2, 1);
    rd(chan_decode_pkg::INT_STATUS_OFS, 32'h0);
    `CHECK("irq", 1'b0, IRQ)
    cmd(chan_decode_pkg::OP_ARM, chan_decode_pkg::GROUP_LVL);
    rd(chan_decode_pkg::INT_ENABLE_OFS, 32'hffff0000);
    cmd(chan_decode_pkg::OP_DISARM, chan_decode_pkg::GROUP_LVL);
    cmd(chan_decode_pkg::OP_ARM, chan_decode_pkg::GROUP_CNT);
    rd(chan_decode_pkg::INT_ENABLE_OFS, 32'h0000ffff);
    cmd(chan_decode_pkg::OP_DISARM, chan_decode_pkg::GROUP_CNT);
    rd(chan_decode_pkg::INT_ENABLE_OFS, 32'h0);
    // inapplicable numbers leave the counter alone
    wr(chan_decode_pkg::PRESET_OFS, 32'h7);
    cmd(chan_decode_pkg::OP_PRESET, 7'd21);
    cmd(chan_decode_pkg::OP_VALUE_READ, chan_decode_pkg::GROUP_CNT);
    rd(chan_decode_pkg::STATUS_OFS, 32'h3);
    cmd(chan_decode_pkg::OP_VALUE_READ, 7'd5);
    rd(chan_decode_pkg::RESULT_OFS, 32'h0);
    // multi reads of channels 2 and 3, by count and by level
    wr(chan_decode_pkg::MASK_OFS, 32'hc);
    cmd(chan_decode_pkg::OP_MULTI_READ, 7'd2);
    rd(chan_decode_pkg::RESULT_OFS, 32'hc);
    rd(8'h48, 32'h2);
    cmd(chan_decode_pkg::OP_MULTI_READ, 7'd19);
    rd(8'h4c, 32'h1);
    rd(8'h50, 32'h0);
    // group edge select: only falling edges count now
    cmd(chan_decode_pkg::OP_EDGE, chan_decode_pkg::GROUP_CNT, 2'h2);
    pulse(2, 1);
    cmd(chan_decode_pkg::OP_VALUE_READ, 7'd2);
    rd(chan_decode_pkg::RESULT_OFS, 32'h3);
    r = $urandom;
    DIN <= r;
    repeat (8) @(posedge CLOCK);
    cmd(chan_decode_pkg::OP_SLOT_READ, 7'd16);
    rd(chan_decode_pkg::RESULT_OFS, {16'h0, r});
    // narrow variant after a second reset
    do_reset();
    wr(chan_decode_pkg::CONFIG_OFS, 32'h0);
    rd(chan_decode_pkg::STATUS_OFS, 32'h0);
    cmd(chan_decode_pkg::OP_ARM, 7'd8);
    cmd(chan_decode_pkg::OP_ARM, 7'd0);
    rd(chan_decode_pkg::INT_ENABLE_OFS, 32'h10001);
    pulse(0, 1);
    cmd(chan_decode_pkg::OP_CONFIGURE, 7'd0);
    rd(chan_decode_pkg::INT_ENABLE_OFS, 32'h0);
    rd(chan_decode_pkg::INT_STATUS_OFS, 32'h0);
    cmd(chan_decode_pkg::OP_VALUE_READ, 7'd0);
    rd(chan_decode_pkg::RESULT_OFS, 32'h0);
    r = $urandom;
    DIN <= r;
    repeat (8) @(posedge CLOCK);
    cmd(chan_decode_pkg::OP_SLOT_READ, 7'd8);
    rd(chan_decode_pkg::RESULT_OFS, {24'h0, r[7:0]});
    wr(chan_decode_pkg::MASK_OFS, 32'h2);
    cmd(chan_decode_pkg::OP_MULTI_SLOT, 7'd8);
    rd(8'h44, {24'h0, r[7:0]});
    cmd(chan_decode_pkg::OP_VALUE_READ, 7'd16);
    rd(chan_decode_pkg::STATUS_OFS, 32'h1);
    wrap_up();
  end
endmodule : digital_input_channel_decode_test
